// >>> verilog/sac_pkg.sv
package sac_pkg;

	// Result width and successive-approximation steps.
	localparam int          RES_W        = 18;
	localparam int          CNT_W        = 5;
	localparam logic [17:0] TRIAL_FIRST  = 18'h20000;
	localparam logic [17:0] CODE_ZERO    = 18'h00000;
	localparam logic [4:0]  BITS_TOTAL   = 5'h12;
	localparam logic [4:0]  CNT_ZERO     = 5'h00;
	localparam logic [4:0]  CNT_ONE      = 5'h01;

	// Clock rate and the least conversion time.
	localparam int          CLK_PERIOD_NS = 25;
	localparam int          T_CONV_MIN_NS = 460;
	localparam int          CONV_CYC_INT  = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0]  CONV_CYC      = CONV_CYC_INT[4:0];

	// Wishbone register byte offsets.
	localparam logic [4:0]  OFF_CTRL     = 5'h00;
	localparam logic [4:0]  OFF_STATUS   = 5'h04;
	localparam logic [4:0]  OFF_RESULT   = 5'h08;
	localparam logic [4:0]  OFF_IRQ_STAT = 5'h0C;
	localparam logic [4:0]  OFF_IRQ_MASK = 5'h10;

	// Field positions.
	localparam int          CTRL_START_BIT   = 0;
	localparam int          ST_BUSY_BIT      = 0;
	localparam int          ST_NAP_BIT       = 1;
	localparam int          ST_CHAIN_BIT     = 2;
	localparam int          ST_SDO_EN_BIT    = 3;
	localparam int          ST_LEFT_LSB      = 8;
	localparam int          IRQ_DONE_BIT     = 0;
	localparam int          IRQ_READOUT_BIT  = 1;
	localparam int          IRQ_OVERRUN_BIT  = 2;
	localparam int          IRQ_W            = 3;
	localparam logic [2:0]  IRQ_ZERO         = 3'h0;
	localparam logic [31:0] WORD_ZERO        = 32'h00000000;

	// Pin synchroniser slots.
	localparam int          PIN_CNV   = 0;
	localparam int          PIN_CHAIN = 1;
	localparam int          PIN_SHARE = 2;
	localparam int          PIN_SCK   = 3;
	localparam int          PIN_N     = 4;

	// Converter phases.
	typedef enum logic [0:0] {
		SAC_ACQUIRE,
		SAC_CONVERT
	} sac_state_type;

endpackage : sac_pkg

// >>> verilog/sac_sar_engine.sv
`timescale 1ns/1ps

module sac_sar_engine
	import sac_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Control.
	input  wire logic              start_i,
	input  wire logic              comp_above_i,
	// Trial word to the capacitor DAC and finished code.
	output logic [RES_W-1:0]       trial_o,
	output logic [RES_W-1:0]       code_o,
	output logic                   done_o
);

	logic [RES_W-1:0] mask_ff;

	// One bit is resolved per step, starting at half the reference.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trial_o <= CODE_ZERO;
			mask_ff <= CODE_ZERO;
			code_o  <= CODE_ZERO;
			done_o  <= 1'b0;
		end else if (start_i) begin
			trial_o <= TRIAL_FIRST;
			mask_ff <= TRIAL_FIRST;
			done_o  <= 1'b0;
		end else if (mask_ff != CODE_ZERO) begin
			// Keep the trial bit when the sample is above it, then try the next weight.
			trial_o <= (comp_above_i ? trial_o : (trial_o & ~mask_ff)) | (mask_ff >> 1);
			mask_ff <= mask_ff >> 1;
			if (mask_ff == {{(RES_W-1){1'b0}}, 1'b1}) begin
				code_o <= comp_above_i ? trial_o : (trial_o & ~mask_ff);
				done_o <= 1'b1;
			end
		end else begin
			done_o <= 1'b0;
		end
	end

endmodule : sac_sar_engine

// >>> verilog/sac_top.sv
`timescale 1ns/1ps

module sac_top
	import sac_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave.
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [4:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	output logic                   irq_o,
	// Converter pins.
	input  wire logic              convert_start_i,
	input  wire logic              chain_mode_i,
	input  wire logic              shared_enable_or_serial_in_i,
	input  wire logic              sck_i,
	output logic                   busy_o,
	output logic                   sdo_o,
	output logic                   sdo_oe_o,
	output logic                   nap_o,
	// Analog core.
	input  wire logic              comp_above_i,
	output logic [RES_W-1:0]       sampling_cap_dac_o,
	output logic                   acquire_o
);

	// Decodes one register offset from the bus address alone; callers qualify the request.
	// Only address bits 4:2 are compared, so byte offsets inside a word alias.
	function automatic logic reg_hit(input logic [4:0] adr, input logic [4:0] off);
		reg_hit = (adr[4:2] == off[4:2]);
	endfunction : reg_hit

	// Synchronised pins and their edges.
	logic [PIN_N-1:0]  pin_raw;
	logic [PIN_N-1:0]  pin_s1_ff;
	logic [PIN_N-1:0]  pin_s2_ff;
	logic              cnv_old_ff;
	logic              sck_old_ff;
	logic              cnv_rise;
	logic              sck_rise;
	logic              chain_lvl;
	logic              share_lvl;
	logic              sdo_en;
	// Phase, engine and result path.
	sac_state_type     state_ff;
	logic [CNT_W-1:0]  conv_cnt_ff;
	logic              sar_start;
	logic              sar_done;
	logic [RES_W-1:0]  sar_code;
	logic [RES_W-1:0]  sar_twos;
	logic [RES_W-1:0]  result_ff;
	logic [RES_W-1:0]  shift_ff;
	logic [CNT_W-1:0]  left_ff;
	// Bus decode and interrupt state.
	logic              sw_start_ff;
	logic              start_req;
	logic              wb_req;
	logic              wr_req;
	logic              rd_req;
	logic [IRQ_W-1:0]  irq_stat_ff;
	logic [IRQ_W-1:0]  irq_mask_ff;
	logic [IRQ_W-1:0]  irq_evt;
	logic              conv_done_evt;
	logic              readout_evt;
	logic              overrun_evt;
	logic [31:0]       nxt_rd_data;

	// Raw pins gathered for the synchroniser.
	assign pin_raw[PIN_CNV]   = convert_start_i;
	assign pin_raw[PIN_CHAIN] = chain_mode_i;
	assign pin_raw[PIN_SHARE] = shared_enable_or_serial_in_i;
	assign pin_raw[PIN_SCK]   = sck_i;

	// Every pin from the host passes two flip-flops before any logic reads it.
	// Edges of convert and serial clock are therefore seen about two cycles late.
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					// The shared pin idles high, so its stages reset high and the
					// output stays released straight after reset.
					pin_s1_ff[gi] <= (gi == PIN_SHARE);
					pin_s2_ff[gi] <= (gi == PIN_SHARE);
				end else begin
					pin_s1_ff[gi] <= pin_raw[gi];
					pin_s2_ff[gi] <= pin_s1_ff[gi];
				end
			end
		end
	endgenerate

	// Previous synchronised levels of convert and serial clock for edge finding.
	// Both reset low, the idle level of these pins, so no false edge follows reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnv_old_ff <= 1'b0;
			sck_old_ff <= 1'b0;
		end else begin
			cnv_old_ff <= pin_s2_ff[PIN_CNV];
			sck_old_ff <= pin_s2_ff[PIN_SCK];
		end
	end

	// Pin interpretation by mode.
	// In chain mode the output is always enabled and the shared pin carries data.
	assign cnv_rise  = pin_s2_ff[PIN_CNV] & ~cnv_old_ff;
	assign sck_rise  = pin_s2_ff[PIN_SCK] & ~sck_old_ff;
	assign chain_lvl = pin_s2_ff[PIN_CHAIN];
	assign share_lvl = pin_s2_ff[PIN_SHARE];
	assign sdo_en    = chain_lvl | ~share_lvl;

	// Wishbone request decode.
	// An acknowledged request is not taken again while the master releases it.
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_req = wb_req & wb_we_i;
	assign rd_req = wb_req & ~wb_we_i;

	// A convert edge or a software start, both honoured only in acquisition.
	assign start_req   = cnv_rise | sw_start_ff;
	assign overrun_evt = start_req & (state_ff == SAC_CONVERT);

	// Software start is a one-cycle pulse from a write of the start bit.
	// Byte lane 0 must be enabled for the start bit to count.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_start_ff <= 1'b0;
		end else begin
			sw_start_ff <= wr_req & reg_hit(wb_adr_i, OFF_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_START_BIT];
		end
	end

	// Phase machine: acquisition (napping) and conversion timed by the own clock.
	// The count runs from the start edge to the cycle that ends the conversion.
	// A start taken while converting is dropped here and only flagged as an overrun.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff    <= SAC_ACQUIRE;
			conv_cnt_ff <= CNT_ZERO;
		end else begin
			case (state_ff)
				SAC_ACQUIRE: begin
					if (start_req) begin
						state_ff    <= SAC_CONVERT;
						conv_cnt_ff <= CONV_CYC;
					end
				end
				SAC_CONVERT: begin
					conv_cnt_ff <= conv_cnt_ff - CNT_ONE;
					if (conv_cnt_ff == CNT_ONE) begin
						state_ff <= SAC_ACQUIRE;
					end
				end
				default: begin
					state_ff    <= SAC_ACQUIRE;
					conv_cnt_ff <= CNT_ZERO;
				end
			endcase
		end
	end

	// Launch of the approximation engine in the cycle the start is taken.
	// Launching here, not a cycle later, settles the last bit one cycle before the
	// timed conversion ends, so the finished code is ready when busy falls.
	assign sar_start = start_req & (state_ff == SAC_ACQUIRE);

	// The engine drives the DAC trial word one weight per cycle.
	// Its trial word is registered inside, so the DAC pins come from flip-flops.
	sac_sar_engine u_sar (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.start_i      (sar_start),
		.comp_above_i (comp_above_i),
		.trial_o      (sampling_cap_dac_o),
		.code_o       (sar_code),
		.done_o       (sar_done)
	);

	// End of conversion: the last timed cycle.
	// Busy, result and shift path all change at the edge that ends this cycle.
	assign conv_done_evt = (state_ff == SAC_CONVERT) & (conv_cnt_ff == CNT_ONE);

	// Busy, nap and acquisition outputs follow the phase, registered.
	// Busy falls as the shift path loads, so the first bit stands when busy is low.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o    <= 1'b0;
			nap_o     <= 1'b1;
			acquire_o <= 1'b1;
		end else if (state_ff == SAC_ACQUIRE && start_req) begin
			busy_o    <= 1'b1;
			nap_o     <= 1'b0;
			acquire_o <= 1'b0;
		end else if (conv_done_evt) begin
			busy_o    <= 1'b0;
			nap_o     <= 1'b1;
			acquire_o <= 1'b1;
		end
	end

	// Offset-binary code turned to two's complement by inverting the MSB.
	assign sar_twos = {~sar_code[RES_W-1], sar_code[RES_W-2:0]};

	// Last finished code, kept for software reads; done coincides with the end of conversion.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_ff <= CODE_ZERO;
		end else if (sar_done) begin
			result_ff <= sar_twos;
		end
	end

	// Shift path: loaded at end of conversion, shifted on serial clock edges.
	// A load wins over a serial edge in the same cycle; the host must not clock then.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_ff <= CODE_ZERO;
			left_ff  <= CNT_ZERO;
			sdo_o    <= 1'b0;
		end else if (conv_done_evt) begin
			shift_ff <= sar_twos;
			left_ff  <= BITS_TOTAL;
			sdo_o    <= sar_twos[RES_W-1];
		end else if (sck_rise && sdo_en) begin
			// Chain input fills from the bottom, so it follows the own bits out.
			// In normal mode zeros fill the bottom instead.
			shift_ff <= {shift_ff[RES_W-2:0], chain_lvl & share_lvl};
			sdo_o    <= shift_ff[RES_W-2];
			if (left_ff != CNT_ZERO) begin
				left_ff <= left_ff - CNT_ONE;
			end
		end
	end

	// Readout complete when the last own bit has been clocked out.
	// Later edges carry only chained or filler bits and raise no further event.
	assign readout_evt = sck_rise & sdo_en & (left_ff == CNT_ONE);

	// Output enable follows the bus enable level in normal mode, always on in chain.
	// It follows the synchronised level, so it changes about three cycles after the pin.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sdo_oe_o <= 1'b0;
		end else begin
			sdo_oe_o <= sdo_en;
		end
	end

	// Interrupt events in their status layout.
	always_comb begin
		irq_evt                  = IRQ_ZERO;
		irq_evt[IRQ_DONE_BIT]    = conv_done_evt;
		irq_evt[IRQ_READOUT_BIT] = readout_evt;
		irq_evt[IRQ_OVERRUN_BIT] = overrun_evt;
	end

	// Sticky status, cleared by a read; a new event in that cycle wins.
	// Only a read of this register clears it; other offsets leave the bits alone.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_ff <= IRQ_ZERO;
		end else if (rd_req && reg_hit(wb_adr_i, OFF_IRQ_STAT)) begin
			irq_stat_ff <= irq_evt;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_evt;
		end
	end

	// Mask register, written over byte lane 0.
	// Other byte lanes carry no mask bits and are ignored.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_ff <= IRQ_ZERO;
		end else if (wr_req && reg_hit(wb_adr_i, OFF_IRQ_MASK) && wb_sel_i[0]) begin
			irq_mask_ff <= wb_dat_i[IRQ_W-1:0];
		end
	end

	// Level interrupt while any unmasked status bit stands.
	// Registered, so the line follows the status one cycle late.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	// Read multiplexer; unmapped offsets read zero.
	// It is sampled only when a read is taken, so its inputs need no holding.
	always_comb begin
		nxt_rd_data = WORD_ZERO;
		if (reg_hit(wb_adr_i, OFF_STATUS)) begin
			nxt_rd_data[ST_BUSY_BIT]                   = busy_o;
			nxt_rd_data[ST_NAP_BIT]                    = nap_o;
			nxt_rd_data[ST_CHAIN_BIT]                  = chain_lvl;
			nxt_rd_data[ST_SDO_EN_BIT]                 = sdo_en;
			nxt_rd_data[ST_LEFT_LSB +: CNT_W]          = left_ff;
		end else if (reg_hit(wb_adr_i, OFF_RESULT)) begin
			nxt_rd_data[RES_W-1:0] = result_ff;
		end else if (reg_hit(wb_adr_i, OFF_IRQ_STAT)) begin
			nxt_rd_data[IRQ_W-1:0] = irq_stat_ff;
		end else if (reg_hit(wb_adr_i, OFF_IRQ_MASK)) begin
			nxt_rd_data[IRQ_W-1:0] = irq_mask_ff;
		end
	end

	// Every request is acknowledged one cycle after it appears.
	// Read data is registered at that same edge and stays until the next read.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= WORD_ZERO;
		end else begin
			wb_ack_o <= wb_req;
			if (rd_req) begin
				wb_dat_o <= nxt_rd_data;
			end
		end
	end

endmodule : sac_top

// >>> testbench/sac_top_assertions.sv
`timescale 1ns/1ps

// Watches the converter pins and the bus handshake at the top ports.
module sac_checker
	import sac_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Bus and pins.
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_ack_o,
	input  wire logic             convert_start_i,
	input  wire logic             chain_mode_i,
	input  wire logic             shared_enable_or_serial_in_i,
	input  wire logic             busy_o,
	input  wire logic             sdo_oe_o,
	input  wire logic             nap_o,
	input  wire logic             acquire_o,
	input  wire logic [RES_W-1:0] sampling_cap_dac_o
);
	logic [5:0] busy_cnt_ff;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Counts the cycles of the current busy stretch.
	always_ff @(posedge clk_i) begin
		if (rst_i || !busy_o) begin
			busy_cnt_ff <= 6'h00;
		end else begin
			busy_cnt_ff <= busy_cnt_ff + 6'h01;
		end
	end

	property p_start;
		$rose(convert_start_i) && !busy_o |-> ##[3:6] busy_o;
	endproperty
	a_start: assert property (p_start) else $error("convert edge left busy low");
	property p_len;
		$fell(busy_o) |-> busy_cnt_ff == CONV_CYC_INT;
	endproperty
	a_len: assert property (p_len) else $error("busy stretch has wrong length");
	property p_phase;
		busy_o |-> !nap_o && !acquire_o;
	endproperty
	a_phase: assert property (p_phase) else $error("nap or acquire during conversion");
	property p_back;
		$fell(busy_o) |-> nap_o && acquire_o;
	endproperty
	a_back: assert property (p_back) else $error("no nap after conversion");
	property p_msb;
		$rose(busy_o) |-> sampling_cap_dac_o == TRIAL_FIRST;
	endproperty
	a_msb: assert property (p_msb) else $error("first trial is not half scale");
	property p_on;
		(chain_mode_i || !shared_enable_or_serial_in_i) [*6] |-> sdo_oe_o;
	endproperty
	a_on: assert property (p_on) else $error("serial output not driven");
	property p_off;
		(!chain_mode_i && shared_enable_or_serial_in_i) [*6] |-> !sdo_oe_o;
	endproperty
	a_off: assert property (p_off) else $error("serial output not released");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus cycle not acknowledged");

	// Main scenarios.
	c_conv: cover property ($fell(busy_o));
	c_chain: cover property (chain_mode_i && $fell(busy_o));
	c_ack: cover property (wb_ack_o);

endmodule : sac_checker

bind sac_top sac_checker sac_checker_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.convert_start_i, .chain_mode_i, .shared_enable_or_serial_in_i, .busy_o, .sdo_oe_o,
	.nap_o, .acquire_o, .sampling_cap_dac_o);

// >>> testbench/sac_host_model.sv
`timescale 1ns/1ps

// Host side: pulses convert, clocks the result out and feeds the chain input.
module sac_host_model (
	// Clock.
	input  wire logic clk_i,
	// Converter pins.
	input  wire logic chain_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      convert_o,
	output logic      sck_o,
	output logic      share_o
);
	// Idle: no convert, serial clock parked low, output disabled.
	initial begin
		convert_o = 1'b0;
		sck_o = 1'b0;
		share_o = 1'b1;
	end

	// Holds convert high long enough for the synchroniser to see the edge.
	task pulse_convert;
		@(posedge clk_i);
		convert_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		convert_o <= 1'b0;
	endtask : pulse_convert

	// Clocks n bits MSB first at 200 ns; a released output reads inverted.
	task shift(input int n, input logic off, input logic [35:0] feed, output logic [35:0] got);
		int i;
		got = 36'h0;
		@(posedge clk_i);
		share_o <= chain_i ? feed[35] : off;
		repeat (6) @(posedge clk_i);
		for (i = 0; i < n; i++) begin
			got[35-i] = sdo_oe_i ? sdo_i : ~sdo_i;
			sck_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b0;
			if (chain_i && i < n - 1) begin
				share_o <= feed[34-i];
			end
			repeat (4) @(posedge clk_i);
		end
		share_o <= chain_i ? ~share_o : 1'b1;
	endtask : shift

endmodule : sac_host_model

// >>> testbench/sac_top_test.sv
`timescale 1ns/1ps

// Runs conversions through the host model and checks results and registers.
module sac_top_test import sac_pkg::*;;
	logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
	logic [4:0]       wb_adr_i;
	logic [3:0]       wb_sel_i;
	logic [31:0]      wb_dat_i, wb_dat_o, rd;
	logic             convert_start_i, chain_mode_i, shared_enable_or_serial_in_i, sck_i;
	logic             busy_o, sdo_o, sdo_oe_o, nap_o, acquire_o;
	logic [RES_W-1:0] sampling_cap_dac_o, level;
	logic [35:0]      got;
	logic [17:0]      vals [5] = '{18'h00000, 18'h3FFFF, 18'h20000, 18'h1FFFF, 18'h12345};
	int               n_mismatch, comparisons, cycles;

	// Device under test; the comparator is modelled from the analog level.
	sac_top sac_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .convert_start_i, .chain_mode_i,
		.shared_enable_or_serial_in_i, .sck_i, .busy_o, .sdo_o, .sdo_oe_o, .nap_o,
		.comp_above_i(level >= sampling_cap_dac_o), .sampling_cap_dac_o, .acquire_o);
	sac_host_model sac_host_model_inst (.clk_i, .chain_i(chain_mode_i), .sdo_i(sdo_o),
		.sdo_oe_i(sdo_oe_o), .convert_o(convert_start_i), .sck_o(sck_i), .share_o(shared_enable_or_serial_in_i));

	// Clock at 40 MHz.
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Cuts a hung run short.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			n_mismatch++;
			conclude();
		end
	end

	task check(input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t ns: got %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	// One classic Wishbone cycle; read data lands in rd.
	task wb(input logic we, input logic [4:0] adr, input logic [31:0] wd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		// Waits for ack with no limit of its own; the cycle timeout ends a hang.
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task rd_chk(input logic [4:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, WORD_ZERO);
		check({4'h0, rd}, {4'h0, exp});
	endtask : rd_chk

	task wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy_o !== lvl && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		check({35'h0, busy_o}, {35'h0, lvl});
	endtask : wait_busy

	task conclude;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// Main sequence.
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, chain_mode_i} = 5'h10;
		{wb_sel_i, wb_adr_i, wb_dat_i, level} = '0;
		{n_mismatch, comparisons, cycles} = '0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(OFF_STATUS, 32'h00000002);
		rd_chk(5'h14, WORD_ZERO);
		wb(1'b1, OFF_IRQ_MASK, WORD_ZERO);
		foreach (vals[i]) begin
			level <= vals[i];
			sac_host_model_inst.pulse_convert();
			wait_busy(1'b1);
			wait_busy(1'b0);
			sac_host_model_inst.shift(18, 1'b0, 36'h0, got);
			check({18'h0, got[35:18]}, {18'h0, vals[i] ^ 18'h20000});
			rd_chk(OFF_RESULT, {14'h0, vals[i] ^ 18'h20000});
			check({35'h0, irq_o}, 36'h0);
		end
		rd_chk(OFF_IRQ_STAT, 32'h00000003);
		wb(1'b1, OFF_IRQ_MASK, 32'h00000007);
		rd_chk(OFF_IRQ_MASK, 32'h00000007);
		level <= 18'h0F0F0;
		sac_host_model_inst.pulse_convert();
		wait_busy(1'b1);
		wb(1'b1, OFF_CTRL, 32'h00000001);
		wait_busy(1'b0);
		repeat (2) @(posedge clk_i);
		check({35'h0, irq_o}, 36'h1);
		rd_chk(OFF_IRQ_STAT, 32'h00000005);
		repeat (2) @(posedge clk_i);
		check({35'h0, irq_o}, 36'h0);
		rd_chk(OFF_STATUS, 32'h00001202);
		sac_host_model_inst.shift(18, 1'b1, 36'h0, got);
		rd_chk(OFF_STATUS, 32'h00001202);
		sac_host_model_inst.shift(18, 1'b0, 36'h0, got);
		check({18'h0, got[35:18]}, {18'h0, 18'h2F0F0});
		chain_mode_i <= 1'b1;
		level <= 18'h2A5C3;
		wb(1'b1, OFF_CTRL, 32'h00000001);
		wait_busy(1'b1);
		wait_busy(1'b0);
		sac_host_model_inst.shift(36, 1'b0, 36'hC35A96E1B, got);
		check(got, {18'h0A5C3, 18'h30D6A});
		conclude();
	end

endmodule : sac_top_test
